// file: verilog/agp_pkg.sv
`default_nettype none
package agp_pkg;
  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [3:0] OFF_ENABLE = 4'hc;
  localparam logic [3:0] OFF_DIR = 4'hd;
  localparam logic [3:0] OFF_LEVEL = 4'he;
  localparam logic [7:0] RESET_ENABLE = 8'h00;
  localparam logic [7:0] RESET_DIR = 8'h00;
  localparam logic [7:0] RESET_LEVEL = 8'h00;
  localparam logic [7:0] MASK_FOUR_PIN = 8'h0f;
  localparam logic [7:0] MASK_EIGHT_PIN = 8'hff;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // ----------------------------------------------------------------
  // Serial command framing
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_READ = 4'h2;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_LAST = 3'h7;

  typedef enum logic [2:0] {
    ST_CMD,
    ST_WCNT,
    ST_RCNT,
    ST_WDATA,
    ST_RDATA,
    ST_SKIP
  } agp_state_t;
endpackage
`default_nettype wire

// file: verilog/agp_spi_shift.sv
`timescale 1ns/1ps
`default_nettype none
module agp_spi_shift (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic mosi_i,
  input wire logic [7:0] tx_byte_i,
  output logic [7:0] rx_byte_o,
  output logic rx_valid_o,
  output logic cs_n_sync_o,
  output logic dout_o,
  output logic dout_oe_o
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // The serial clock is oversampled, so the host must keep each SCLK
  // phase at least three system clocks long.
  logic sclk_s1_q, sclk_s2_q, sclk_prev_q;
  logic cs_s1_q, cs_s2_q, mosi_s1_q, mosi_s2_q;
  logic [2:0] bit_q, bit_d;
  logic [6:0] rx_sr_q, rx_sr_d;
  logic [7:0] tx_sr_q, tx_sr_d, rx_byte_d;
  logic dout_d, oe_d, rx_valid_d;
  logic rise, fall;

  assign rise = sclk_s2_q & ~sclk_prev_q;
  assign fall = ~sclk_s2_q & sclk_prev_q;

  // ----------------------------------------------------------------
  // Shifter
  // ----------------------------------------------------------------
  always_comb begin
    bit_d = bit_q;
    rx_sr_d = rx_sr_q;
    tx_sr_d = tx_sr_q;
    rx_byte_d = rx_byte_o;
    dout_d = dout_o;
    oe_d = 1'b1;
    rx_valid_d = 1'b0;
    if (cs_s2_q) begin
      bit_d = agp_pkg::BIT_FIRST;
      dout_d = 1'b0;
      oe_d = 1'b0;
    end else begin
      if (rise) begin
        if (bit_q == agp_pkg::BIT_FIRST) begin
          dout_d = tx_byte_i[7];
          tx_sr_d = {tx_byte_i[6:0], 1'b0};
        end else begin
          dout_d = tx_sr_q[7];
          tx_sr_d = {tx_sr_q[6:0], 1'b0};
        end
      end
      if (fall) begin
        rx_sr_d = {rx_sr_q[5:0], mosi_s2_q};
        bit_d = bit_q + 3'h1;
        if (bit_q == agp_pkg::BIT_LAST) begin
          rx_byte_d = {rx_sr_q, mosi_s2_q};
          rx_valid_d = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      sclk_s1_q <= 1'b0;
      sclk_s2_q <= 1'b0;
      sclk_prev_q <= 1'b0;
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      mosi_s1_q <= 1'b0;
      mosi_s2_q <= 1'b0;
      bit_q <= agp_pkg::BIT_FIRST;
      rx_sr_q <= 7'h00;
      tx_sr_q <= 8'h00;
      rx_byte_o <= 8'h00;
      rx_valid_o <= 1'b0;
      dout_o <= 1'b0;
      dout_oe_o <= 1'b0;
    end else if (ce_i) begin
      sclk_s1_q <= sclk_i;
      sclk_s2_q <= sclk_s1_q;
      sclk_prev_q <= sclk_s2_q;
      cs_s1_q <= cs_n_i;
      cs_s2_q <= cs_s1_q;
      mosi_s1_q <= mosi_i;
      mosi_s2_q <= mosi_s1_q;
      bit_q <= bit_d;
      rx_sr_q <= rx_sr_d;
      tx_sr_q <= tx_sr_d;
      rx_byte_o <= rx_byte_d;
      rx_valid_o <= rx_valid_d;
      dout_o <= dout_d;
      dout_oe_o <= oe_d;
    end
  end

  assign cs_n_sync_o = cs_s2_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_sample_on_fall: assert property (@(posedge mclk_i) disable iff (reset_i)
    $rose(rx_valid_o) |-> $past(fall)) else $error("byte completed without falling edge");
  a_launch_on_rise: assert property (@(posedge mclk_i) disable iff (reset_i)
    (dout_oe_o && $past(dout_oe_o) && $changed(dout_o)) |-> $past(rise))
    else $error("output bit changed away from a rising edge");
endmodule
`default_nettype wire

// file: verilog/agp_gpio_port.sv
`timescale 1ns/1ps
`default_nettype none
module agp_gpio_port #(
  parameter bit EIGHT_PIN = 1'b1
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic din_i,
  output logic dout_o,
  output logic dout_oe_o,
  input wire logic [7:0] pin_in_i,
  output logic [7:0] pin_out_o,
  output logic [7:0] pin_oe_o
);
  localparam logic [7:0] PIN_MASK = EIGHT_PIN ? agp_pkg::MASK_EIGHT_PIN
                                              : agp_pkg::MASK_FOUR_PIN;

  // ----------------------------------------------------------------
  // Register read decode
  // ----------------------------------------------------------------
  function automatic logic [7:0] read_reg(input logic [3:0] addr, input logic [7:0] en,
                                          input logic [7:0] dir, input logic [7:0] level,
                                          input logic [7:0] pins);
    logic [7:0] sampled;
    sampled = en & dir;
    unique case (addr)
      agp_pkg::OFF_ENABLE: read_reg = en & PIN_MASK;
      agp_pkg::OFF_DIR: read_reg = dir & PIN_MASK;
      // Only enabled inputs show the pin; outputs and idle pins show the store.
      agp_pkg::OFF_LEVEL: read_reg = ((level & ~sampled) | (pins & sampled)) & PIN_MASK;
      default: read_reg = agp_pkg::READ_UNMAPPED;
    endcase
  endfunction

  // Pin levels pass two flops before a read sees them, so an input read
  // shows the pin as it stood a few clocks before its byte is loaded.
  logic [7:0] rx_byte, pin_s1_q, pin_s2_q;
  logic rx_valid, cs_n_sync;
  agp_pkg::agp_state_t state_q, state_d;
  logic [3:0] addr_q, addr_d;
  logic [7:0] count_q, count_d, tx_byte_q, tx_byte_d;
  logic [7:0] en_q, en_d, dir_q, dir_d, level_q, level_d, oe_d;
  logic wr_en;

  agp_spi_shift u_shift (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .sclk_i(sclk_i),
    .cs_n_i(cs_n_i),
    .mosi_i(din_i),
    .tx_byte_i(tx_byte_q),
    .rx_byte_o(rx_byte),
    .rx_valid_o(rx_valid),
    .cs_n_sync_o(cs_n_sync),
    .dout_o(dout_o),
    .dout_oe_o(dout_oe_o)
  );

  // ----------------------------------------------------------------
  // Command sequencer and registers
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    addr_d = addr_q;
    count_d = count_q;
    wr_en = 1'b0;
    if (cs_n_sync) begin
      state_d = agp_pkg::ST_CMD;
    end else if (rx_valid) begin
      unique case (state_q)
        agp_pkg::ST_CMD: begin
          addr_d = rx_byte[3:0];
          if (rx_byte[7:4] == agp_pkg::CMD_WRITE) begin
            state_d = agp_pkg::ST_WCNT;
          end else if (rx_byte[7:4] == agp_pkg::CMD_READ) begin
            state_d = agp_pkg::ST_RCNT;
          end else begin
            state_d = agp_pkg::ST_SKIP;
          end
        end
        agp_pkg::ST_WCNT: begin
          count_d = rx_byte;
          state_d = agp_pkg::ST_WDATA;
        end
        agp_pkg::ST_RCNT: begin
          count_d = rx_byte;
          state_d = agp_pkg::ST_RDATA;
        end
        // The count byte is one less than the number of data bytes, so a
        // count of zero still moves one byte before the frame is skipped.
        agp_pkg::ST_WDATA, agp_pkg::ST_RDATA: begin
          wr_en = (state_q == agp_pkg::ST_WDATA);
          addr_d = addr_q + 4'h1;
          count_d = count_q - 8'h01;
          if (count_q == 8'h00) begin
            state_d = agp_pkg::ST_SKIP;
          end
        end
        // Unknown commands and trailing bytes end here until the select rises.
        agp_pkg::ST_SKIP: begin
          state_d = agp_pkg::ST_SKIP;
        end
      endcase
    end
  end

  always_comb begin
    en_d = en_q;
    dir_d = dir_q;
    level_d = level_q;
    if (wr_en) begin
      unique case (addr_q)
        agp_pkg::OFF_ENABLE: en_d = rx_byte & PIN_MASK;
        agp_pkg::OFF_DIR: dir_d = rx_byte & PIN_MASK;
        // Input pins keep the value in store only; the drive below stays off.
        agp_pkg::OFF_LEVEL: level_d = rx_byte & PIN_MASK;
        default: level_d = level_q;
      endcase
    end
    // Enable and direction are taken from the next values so a pin starts
    // driving in the very cycle its write lands.
    oe_d = en_d & ~dir_d & PIN_MASK;
    tx_byte_d = (state_d == agp_pkg::ST_RDATA) ?
                read_reg(addr_d, en_d, dir_d, level_d, pin_s2_q) : agp_pkg::READ_UNMAPPED;
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    // Reset leaves every shared pin analog and undriven.
    if (reset_i) begin
      pin_s1_q <= 8'h00;
      pin_s2_q <= 8'h00;
      state_q <= agp_pkg::ST_CMD;
      addr_q <= 4'h0;
      count_q <= 8'h00;
      tx_byte_q <= 8'h00;
      en_q <= agp_pkg::RESET_ENABLE;
      dir_q <= agp_pkg::RESET_DIR;
      level_q <= agp_pkg::RESET_LEVEL;
      pin_out_o <= agp_pkg::RESET_LEVEL;
      pin_oe_o <= 8'h00;
    end else if (ce_i) begin
      pin_s1_q <= pin_in_i;
      pin_s2_q <= pin_s1_q;
      state_q <= state_d;
      addr_q <= addr_d;
      count_q <= count_d;
      tx_byte_q <= tx_byte_d;
      en_q <= en_d;
      dir_q <= dir_d;
      level_q <= level_d;
      pin_out_o <= level_d;
      pin_oe_o <= oe_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  a_reset_all_low: assert property ($fell(reset_i) |-> (pin_out_o == 8'h00)
    && (pin_oe_o == 8'h00)) else $error("pins not low and idle after reset");
  a_output_reads_store: assert property ((state_q == agp_pkg::ST_RDATA) && !rx_valid
    && !cs_n_sync && ce_i && (addr_q == agp_pkg::OFF_LEVEL)
    |=> ((tx_byte_q ^ $past(level_q)) & ~$past(dir_q) & PIN_MASK) == 8'h00)
    else $error("output pin read did not return stored level");
  a_input_not_driven: assert property ((pin_oe_o & dir_q) == 8'h00)
    else $error("input pin is being driven");
  a_reserved_zero: assert property (!EIGHT_PIN |-> ((level_q | dir_q | en_q)
    & ~agp_pkg::MASK_FOUR_PIN) == 8'h00) else $error("reserved bits not zero");
  a_level_write: assert property (wr_en && ce_i && (addr_q == agp_pkg::OFF_LEVEL)
    |=> level_q == ($past(rx_byte) & PIN_MASK)) else $error("level write not stored");
  a_dir_sets_drive: assert property (wr_en && ce_i && (addr_q == agp_pkg::OFF_DIR)
    |=> pin_oe_o == (en_q & ~$past(rx_byte) & PIN_MASK)) else $error("direction not applied");
  a_enable_gates_drive: assert property ((pin_oe_o & ~en_q) == 8'h00)
    else $error("disabled pin is being driven");
  a_drive_on_write: assert property (wr_en && ce_i && (addr_q == agp_pkg::OFF_LEVEL)
    |=> (pin_out_o == ($past(rx_byte) & PIN_MASK)) && (pin_oe_o == $past(en_q & ~dir_q)))
    else $error("pin not driven right after level write");
  a_enable_write: assert property (wr_en && ce_i && (addr_q == agp_pkg::OFF_ENABLE)
    |=> en_q == ($past(rx_byte) & PIN_MASK)) else $error("enable write not stored");
  a_input_reads_pin: assert property ((state_q == agp_pkg::ST_RDATA) && !rx_valid
    && !cs_n_sync && ce_i && (addr_q == agp_pkg::OFF_LEVEL)
    |=> ((tx_byte_q ^ $past(pin_s2_q)) & $past(en_q & dir_q) & PIN_MASK) == 8'h00)
    else $error("input pin read did not return pin level");
  a_unmapped_reads_zero: assert property ((state_q == agp_pkg::ST_RDATA) && !rx_valid
    && !cs_n_sync && ce_i && (addr_q != agp_pkg::OFF_ENABLE) && (addr_q != agp_pkg::OFF_DIR)
    && (addr_q != agp_pkg::OFF_LEVEL) |=> tx_byte_q == agp_pkg::READ_UNMAPPED)
    else $error("unmapped register read not zero");
  a_skip_no_write: assert property ((state_q == agp_pkg::ST_SKIP)
    |=> $stable(en_q) && $stable(dir_q) && $stable(level_q))
    else $error("register changed outside data bytes");
  a_freeze_state: assert property (!ce_i |=> $stable(state_q) && $stable(level_q)
    && $stable(pin_oe_o) && $stable(tx_byte_q))
    else $error("state moved while clock enable low");

  // ----------------------------------------------------------------
  // Covers
  // ----------------------------------------------------------------
  // Each cover marks a kind of frame that the bench is meant to reach.
  c_write_level: cover property (wr_en && ce_i && (addr_q == agp_pkg::OFF_LEVEL));
  c_read_level: cover property ((state_q == agp_pkg::ST_RDATA) && (addr_q == agp_pkg::OFF_LEVEL));
  c_input_read: cover property ((state_q == agp_pkg::ST_RDATA) && ((en_q & dir_q) != 8'h00));
  c_write_dir: cover property (wr_en && ce_i && (addr_q == agp_pkg::OFF_DIR));
  c_skip_bytes: cover property ((state_q == agp_pkg::ST_SKIP) && rx_valid);
endmodule
`default_nettype wire

// file: dv/agp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module agp_host_model (
  input wire logic mclk_i,
  input wire logic miso_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic mosi_o
);
  // ----------------------------------------------------------------
  // Serial master, mode 1
  // ----------------------------------------------------------------
  // Half periods of five system clocks keep every phase well above the
  // three-clock synchroniser delay, so the device never misses an edge.
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      @(posedge mclk_i);
      sclk_o <= 1'b1;
      mosi_o <= tx[i];
      repeat (5) @(posedge mclk_i);
      sclk_o <= 1'b0;
      rx[i] = miso_i;
      repeat (4) @(posedge mclk_i);
    end
  endtask

  task automatic frame(input logic [7:0] cmd, input logic [7:0] cnt, input logic [23:0] wd,
                       output logic [23:0] rd);
    logic [7:0] junk;
    @(posedge mclk_i);
    cs_n_o <= 1'b0;
    repeat (3) @(posedge mclk_i);
    xfer(cmd, junk);
    xfer(cnt, junk);
    for (int k = 0; k < 3; k++) begin
      xfer(wd[23 - 8 * k -: 8], junk);
      rd[23 - 8 * k -: 8] = junk;
    end
    repeat (3) @(posedge mclk_i);
    cs_n_o <= 1'b1;
    // A released data line shows the inverse level, never a stale copy.
    mosi_o <= ~mosi_o;
    repeat (6) @(posedge mclk_i);
  endtask
endmodule
`default_nettype wire

// file: dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] ext = 8'h00;
  logic clash = 1'b0;
  logic sel = 1'b0;
  logic ce = 1'b1;
  logic sclk, cs_n, mosi, cs8, cs4, dout8, doe8, dout4, doe4;
  logic [7:0] po8, oe8, po4, oe4, pi8, pi4;
  logic [23:0] r;
  int fail_count = 0;
  int tests_run = 0;
  int cycles = 0;

  always #20 mclk_i = ~mclk_i;

  // ----------------------------------------------------------------
  // Pin wires
  // ----------------------------------------------------------------
  // The clash flag lets an outside load fight a driven pin, so a read of
  // an output bit can be told apart from a sample of the wire.
  assign pi8 = (oe8 & (po8 ^ {8{clash}})) | (~oe8 & ext);
  assign pi4 = (oe4 & (po4 ^ {8{clash}})) | (~oe4 & ext);
  // Each build has its own select, so frames to the four-pin build can
  // keep its reserved bits at zero while the eight-pin build gets full bytes.
  assign cs8 = cs_n | sel;
  assign cs4 = cs_n | ~sel;

  agp_gpio_port #(.EIGHT_PIN(1'b1)) u_dut (.mclk_i(mclk_i), .reset_i(reset_i), .ce_i(ce),
    .sclk_i(sclk), .cs_n_i(cs8), .din_i(mosi), .dout_o(dout8), .dout_oe_o(doe8),
    .pin_in_i(pi8), .pin_out_o(po8), .pin_oe_o(oe8));
  agp_gpio_port #(.EIGHT_PIN(1'b0)) u_dut4 (.mclk_i(mclk_i), .reset_i(reset_i), .ce_i(ce),
    .sclk_i(sclk), .cs_n_i(cs4), .din_i(mosi), .dout_o(dout4), .dout_oe_o(doe4),
    .pin_in_i(pi4), .pin_out_o(po4), .pin_oe_o(oe4));
  agp_host_model u_host (.mclk_i(mclk_i), .miso_i(sel ? dout4 : dout8), .sclk_o(sclk),
    .cs_n_o(cs_n), .mosi_o(mosi));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [23:0] exp, input logic [23:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic s, input logic [7:0] en, input logic [7:0] dir,
                    input logic [7:0] lvl);
    logic [23:0] junk;
    @(posedge mclk_i);
    sel <= s;
    u_host.frame(8'h4c, 8'h02, {en, dir, lvl}, junk);
    repeat (4) @(posedge mclk_i);
  endtask

  task automatic rd(input logic s);
    @(posedge mclk_i);
    sel <= s;
    u_host.frame(8'h2c, 8'h02, 24'h000000, r);
  endtask

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    check("pins after reset", 24'h000000, {oe8, po8, oe4});
    rd(1'b0);
    check("regs eight after reset", 24'h000000, r);
    rd(1'b1);
    check("regs four after reset", 24'h000000, r);
    check("drive released", 24'h000000, {22'h0, doe4, doe8});
    $display("t_reset done");
  endtask

  task automatic t_output();
    @(posedge mclk_i);
    ext <= 8'h5a;
    clash <= 1'b1;
    wr(1'b0, 8'hff, 8'h00, 8'ha5);
    wr(1'b1, 8'h0f, 8'h00, 8'h05);
    check("eight drive", 24'h00ffa5, {8'h00, oe8, po8});
    check("four drive", 24'h000f05, {8'h00, oe4, po4});
    rd(1'b0);
    check("eight output read", 24'hff00a5, r);
    rd(1'b1);
    check("four output read", 24'h0f0005, r);
    $display("t_output done");
  endtask

  task automatic t_input();
    logic [23:0] junk;
    @(posedge mclk_i);
    clash <= 1'b0;
    ext <= 8'hc3;
    wr(1'b0, 8'hff, 8'hff, 8'h96);
    check("input not driven", 24'h000000, {16'h0, oe8});
    rd(1'b0);
    check("input read", 24'hffffc3, r);
    u_host.frame(8'h4d, 8'h00, 24'hf05555, junk);
    repeat (4) @(posedge mclk_i);
    check("stored level driven", 24'h000f96, {8'h00, oe8, po8});
    wr(1'b1, 8'h0f, 8'h03, 8'h09);
    check("four partial out", 24'h000c09, {8'h00, oe4, po4});
    rd(1'b1);
    check("four mixed read", 24'h0f030b, r);
    $display("t_input done");
  endtask

  task automatic t_disabled();
    logic [23:0] junk;
    wr(1'b0, 8'h00, 8'h00, 8'h3c);
    wr(1'b1, 8'h00, 8'h00, 8'h0c);
    check("disabled pins", 24'h000000, {8'h00, oe8, oe4});
    rd(1'b0);
    check("disabled read", 24'h00003c, r);
    rd(1'b1);
    check("four disabled read", 24'h00000c, r);
    @(posedge mclk_i);
    sel <= 1'b0;
    u_host.frame(8'h23, 8'h00, 24'h000000, junk);
    check("unmapped read", 24'h00, {16'h0, junk[23:16]});
    $display("t_disabled done");
  endtask

  task automatic t_freeze();
    @(posedge mclk_i);
    ce <= 1'b0;
    wr(1'b0, 8'hff, 8'h00, 8'hff);
    ce <= 1'b1;
    repeat (4) @(posedge mclk_i);
    check("frozen pins", 24'h00003c, {8'h00, oe8, po8});
    rd(1'b0);
    check("frozen regs", 24'h00003c, r);
    $display("t_freeze done");
  endtask

  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      $display("[ERR] timeout expected end seen hang");
      stop_test();
    end
  end

  initial begin
    repeat (12) @(posedge mclk_i);
    reset_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    t_reset();
    t_output();
    t_input();
    t_disabled();
    t_freeze();
    stop_test();
  end
endmodule
`default_nettype wire
